/* File: logic/lpdc_cfg.svh */
`ifndef LPDC_CFG_SVH
`define LPDC_CFG_SVH

// configuration-space offsets of the two diagnostic registers
`define LPDC_OFS_ONE      8'hc4
`define LPDC_OFS_TWO      8'hc8

// reset values
`define LPDC_RST_ONE      32'h00120108
`define LPDC_RST_TWO      32'h32142000

// bits that software may change; everything else holds its reset value
`define LPDC_WMASK_ONE    32'h001fffff
`define LPDC_WMASK_TWO    32'hffff1fbf

// first register fields
`define LPDC_SEP_HI       20
`define LPDC_SEP_LO       18
`define LPDC_SHR_HI       17
`define LPDC_SHR_LO       15
`define LPDC_RSVD_HI      31
`define LPDC_RSVD_LO      21
`define LPDC_SUPP_BIT     10
`define LPDC_L1T_HI       9
`define LPDC_L1T_LO       6
`define LPDC_L0T_HI       5
`define LPDC_L0T_LO       2

// second register fields
`define LPDC_FTS_SEP_HI   31
`define LPDC_FTS_SEP_LO   24
`define LPDC_FTS_SHR_HI   23
`define LPDC_FTS_SHR_LO   16

// timing, in picoseconds
`define LPDC_CLK_PS       40000
`define LPDC_L1_UNIT_PS   512000
`define LPDC_L0S_UNIT_PS  16000
`define LPDC_CEIL_CYC(t)  ((((t) + `LPDC_CLK_PS - 1) / `LPDC_CLK_PS) > 0 ? \
                           (((t) + `LPDC_CLK_PS - 1) / `LPDC_CLK_PS) : 1)
`define LPDC_L1_TICK_CYC  `LPDC_CEIL_CYC(`LPDC_L1_UNIT_PS)
`define LPDC_L0S_TICK_CYC `LPDC_CEIL_CYC(`LPDC_L0S_UNIT_PS)
`define LPDC_CNT_MAX      4'hf

`endif

/* File: logic/lpdc_pkg.sv */
package lpdc_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } lpdc_cfg_req_t;

endpackage

/* File: logic/lpdc_top.sv */
// How it works
// - shared clock bit set: report separate-clock L1 exit latency field.
// - shared clock bit clear: report shared-clock L1 exit latency field.
// - both L1 exit latency fields reset to 100b and are read-write.
// - suppress bit 10 blocks secondary bus reset from bridge control; resets to 0.
// - bits 9:6 set L1 entry timer in 512 ns units, reset 0100b.
// - bits 5:2 set standby entry timer in 62.5 MHz ticks, each stretched to one core clock, reset 0010b.
// - upper reserved bits of first register read zero, writes ignored.
// - every writable field returns to default on any reset.
// - shared clock bit clear: send fast training count from bits 31:24.
// - shared clock bit set: send fast training count from bits 23:16.
`include "lpdc_cfg.svh"

module lpdc_top (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire lpdc_pkg::lpdc_cfg_req_t cfg_req_i,
  input  wire logic                   shared_refclk_config_bit_i,
  input  wire logic                   secondary_bus_reset_request_i,
  input  wire logic                   link_idle_i,
  output logic [31:0]                 cfg_rdata_o,
  output logic [2:0]                  reported_l1_exit_latency_o,
  output logic [7:0]                  fast_train_count_o,
  output logic                        secondary_bus_reset_o,
  output logic                        l1_entry_req_o,
  output logic                        standby_entry_req_o
);

  logic [31:0] reg_one_ff, nxt_reg_one;
  logic [31:0] reg_two_ff, nxt_reg_two;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [2:0]  lat_ff, nxt_lat;
  logic [7:0]  fts_ff, nxt_fts;
  logic        sbr_ff, nxt_sbr;
  logic [3:0]  l1_pre_ff, nxt_l1_pre;
  logic [3:0]  l1_cnt_ff, nxt_l1_cnt;
  logic [3:0]  l0_pre_ff, nxt_l0_pre;
  logic [3:0]  l0_cnt_ff, nxt_l0_cnt;
  logic        l1_req_ff, nxt_l1_req;
  logic        l0_req_ff, nxt_l0_req;
  logic [3:0]  l1_timer;
  logic [3:0]  l0_timer;

  // byte-enabled merge restricted to writable bits; lanes with a low enable keep their old value
  function automatic logic [31:0] lpdc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction

  // one prescaled idle counter; saturates so a long idle keeps the request up
  function automatic logic [7:0] lpdc_tick(input logic idle, input logic [3:0] pre,
                                           input logic [3:0] cnt, input logic [3:0] last);
    logic [3:0] p;
    logic [3:0] c;
    p = pre;
    c = cnt;
    if (!idle)
    begin
      p = 4'h0;
      c = 4'h0;
    end
    else if (pre == last)
    begin
      p = 4'h0;
      if (cnt != `LPDC_CNT_MAX)
        c = cnt + 4'h1;
    end
    else
      p = pre + 4'h1;
    return {p, c};
  endfunction

  assign l1_timer = reg_one_ff[`LPDC_L1T_HI:`LPDC_L1T_LO];
  assign l0_timer = reg_one_ff[`LPDC_L0T_HI:`LPDC_L0T_LO];

  always_comb
  begin
    nxt_reg_one = reg_one_ff;
    nxt_reg_two = reg_two_ff;
    nxt_rdata   = rdata_ff;
    // reserved upper bits are outside the write mask, so they stay zero
    if (cfg_req_i.wr && cfg_req_i.addr == `LPDC_OFS_ONE)
      nxt_reg_one = lpdc_merge(reg_one_ff, cfg_req_i.wdata, cfg_req_i.be, `LPDC_WMASK_ONE);
    if (cfg_req_i.wr && cfg_req_i.addr == `LPDC_OFS_TWO)
      nxt_reg_two = lpdc_merge(reg_two_ff, cfg_req_i.wdata, cfg_req_i.be, `LPDC_WMASK_TWO);
    if (cfg_req_i.rd)
    begin
      case (cfg_req_i.addr)
        `LPDC_OFS_ONE: nxt_rdata = reg_one_ff;
        `LPDC_OFS_TWO: nxt_rdata = reg_two_ff;
        default:       nxt_rdata = 32'h00000000;
      endcase
    end
    nxt_lat = shared_refclk_config_bit_i ? reg_one_ff[`LPDC_SEP_HI:`LPDC_SEP_LO]
                                         : reg_one_ff[`LPDC_SHR_HI:`LPDC_SHR_LO];
    nxt_fts = shared_refclk_config_bit_i ? reg_two_ff[`LPDC_FTS_SHR_HI:`LPDC_FTS_SHR_LO]
                                         : reg_two_ff[`LPDC_FTS_SEP_HI:`LPDC_FTS_SEP_LO];
    nxt_sbr = secondary_bus_reset_request_i && !reg_one_ff[`LPDC_SUPP_BIT];
    // a standby tick is shorter than one core clock, so each unit stretches to a whole cycle;
    // the l1 unit rounds up, so entry is never requested before the programmed time
    {nxt_l1_pre, nxt_l1_cnt} = lpdc_tick(link_idle_i, l1_pre_ff, l1_cnt_ff,
                                         4'(`LPDC_L1_TICK_CYC - 1));
    {nxt_l0_pre, nxt_l0_cnt} = lpdc_tick(link_idle_i, l0_pre_ff, l0_cnt_ff,
                                         4'(`LPDC_L0S_TICK_CYC - 1));
    nxt_l1_req = link_idle_i && (l1_cnt_ff >= l1_timer);
    nxt_l0_req = link_idle_i && (l0_cnt_ff >= l0_timer);
  end

  // rst_i is the merged fundamental, global and power-on reset
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      reg_one_ff <= `LPDC_RST_ONE;
      reg_two_ff <= `LPDC_RST_TWO;
      rdata_ff   <= 32'h00000000;
      lat_ff     <= 3'h0;
      fts_ff     <= 8'h00;
      sbr_ff     <= 1'b0;
      l1_pre_ff  <= 4'h0;
      l1_cnt_ff  <= 4'h0;
      l0_pre_ff  <= 4'h0;
      l0_cnt_ff  <= 4'h0;
      l1_req_ff  <= 1'b0;
      l0_req_ff  <= 1'b0;
    end
    else
    begin
      reg_one_ff <= nxt_reg_one;
      reg_two_ff <= nxt_reg_two;
      rdata_ff   <= nxt_rdata;
      lat_ff     <= nxt_lat;
      fts_ff     <= nxt_fts;
      sbr_ff     <= nxt_sbr;
      l1_pre_ff  <= nxt_l1_pre;
      l1_cnt_ff  <= nxt_l1_cnt;
      l0_pre_ff  <= nxt_l0_pre;
      l0_cnt_ff  <= nxt_l0_cnt;
      l1_req_ff  <= nxt_l1_req;
      l0_req_ff  <= nxt_l0_req;
    end
  end

  assign cfg_rdata_o                = rdata_ff;
  assign reported_l1_exit_latency_o = lat_ff;
  assign fast_train_count_o         = fts_ff;
  assign secondary_bus_reset_o      = sbr_ff;
  assign l1_entry_req_o             = l1_req_ff;
  assign standby_entry_req_o        = l0_req_ff;

  default clocking dflt_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_LAT_SEPARATE: assert property (
    shared_refclk_config_bit_i |=> reported_l1_exit_latency_o == $past(reg_one_ff[`LPDC_SEP_HI:`LPDC_SEP_LO]))
    else $error("latency not taken from separate-clock field");
  AST_LAT_SHARED: assert property (
    !shared_refclk_config_bit_i |=> reported_l1_exit_latency_o == $past(reg_one_ff[`LPDC_SHR_HI:`LPDC_SHR_LO]))
    else $error("latency not taken from shared-clock field");
  AST_RESET_VALUES: assert property (
    $fell(rst_i) |-> reg_one_ff == `LPDC_RST_ONE && reg_two_ff == `LPDC_RST_TWO)
    else $error("register defaults wrong after reset");
  AST_RESET_OUTPUTS: assert property (
    $fell(rst_i) |-> !secondary_bus_reset_o && !l1_entry_req_o && !standby_entry_req_o && cfg_rdata_o == '0)
    else $error("outputs not cleared by reset");
  AST_SUPPRESS: assert property (
    secondary_bus_reset_request_i ##0 reg_one_ff[`LPDC_SUPP_BIT] |=> !secondary_bus_reset_o)
    else $error("secondary reset not suppressed");
  AST_PASS_RESET: assert property (
    secondary_bus_reset_request_i && !reg_one_ff[`LPDC_SUPP_BIT] |=> secondary_bus_reset_o)
    else $error("secondary reset not passed");
  AST_RSVD_READ: assert property (
    cfg_req_i.rd && cfg_req_i.addr == `LPDC_OFS_ONE |=> cfg_rdata_o[`LPDC_RSVD_HI:`LPDC_RSVD_LO] == '0)
    else $error("reserved bits read nonzero");
  AST_RSVD_WRITE: assert property (
    cfg_req_i.wr && cfg_req_i.addr == `LPDC_OFS_ONE |=> reg_one_ff[`LPDC_RSVD_HI:`LPDC_RSVD_LO] == '0)
    else $error("write reached reserved bits");
  AST_READ_ONE: assert property (
    cfg_req_i.rd && cfg_req_i.addr == `LPDC_OFS_ONE |=> cfg_rdata_o == $past(reg_one_ff))
    else $error("first register read returned wrong data");
  AST_WRITE_SEP: assert property (
    cfg_req_i.wr && cfg_req_i.addr == `LPDC_OFS_ONE && cfg_req_i.be[2]
    |=> reg_one_ff[`LPDC_SEP_HI:`LPDC_SEP_LO] == $past(cfg_req_i.wdata[`LPDC_SEP_HI:`LPDC_SEP_LO]))
    else $error("separate-clock latency field not written");
  AST_WRITE_FTS: assert property (
    cfg_req_i.wr && cfg_req_i.addr == `LPDC_OFS_TWO && cfg_req_i.be[3]
    |=> reg_two_ff[`LPDC_FTS_SEP_HI:`LPDC_FTS_SEP_LO] == $past(cfg_req_i.wdata[`LPDC_FTS_SEP_HI:`LPDC_FTS_SEP_LO]))
    else $error("fast training count field not written");
  AST_FTS_SEL: assert property (
    !shared_refclk_config_bit_i |=> fast_train_count_o == $past(reg_two_ff[`LPDC_FTS_SEP_HI:`LPDC_FTS_SEP_LO]))
    else $error("fast training count from wrong field");
  AST_FTS_SHARED: assert property (
    shared_refclk_config_bit_i |=> fast_train_count_o == $past(reg_two_ff[`LPDC_FTS_SHR_HI:`LPDC_FTS_SHR_LO]))
    else $error("shared-clock fast training count wrong");
  AST_L1_UNIT: assert property (
    link_idle_i && l1_pre_ff != 4'(`LPDC_L1_TICK_CYC - 1) |=> l1_cnt_ff == $past(l1_cnt_ff))
    else $error("l1 count advanced inside one 512 ns unit");
  AST_L1_REQ_SET: assert property (
    link_idle_i && l1_cnt_ff >= l1_timer |=> l1_entry_req_o)
    else $error("l1 entry not requested when timer expired");
  AST_L0_REQ_SET: assert property (
    link_idle_i && l0_cnt_ff >= l0_timer |=> standby_entry_req_o)
    else $error("standby entry not requested when timer expired");
  AST_L1_EARLY: assert property (
    $rose(l1_entry_req_o) |-> $past(l1_cnt_ff) >= $past(l1_timer))
    else $error("l1 entry requested early");
  AST_ACTIVITY: assert property (
    !link_idle_i |=> !l1_entry_req_o && !standby_entry_req_o ##0 l1_cnt_ff == 4'h0)
    else $error("entry request or count survived activity");
  AST_L1_TIME: assert property (
    !link_idle_i ##1 link_idle_i [*8] |-> !l1_entry_req_o || l1_timer == 4'h0)
    else $error("l1 entry requested before one 512 ns unit");
  AST_L0_TIME: assert property (
    $rose(standby_entry_req_o) |-> $past(l0_cnt_ff) >= $past(l0_timer))
    else $error("standby entry requested early");

endmodule

/* File: testbench/lpdc_cfg_agent.sv */
`include "lpdc_cfg.svh"

// stands in for config software and the loader; one access per call
module lpdc_cfg_agent (
  input  wire logic                    core_clk_i,
  output lpdc_pkg::lpdc_cfg_req_t      cfg_req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cfg_req_o = '0;

  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] wd;
    wd = (a == `LPDC_OFS_ONE) ? (d & 32'hffff87fc) : d;
    @(negedge core_clk_i);
    cfg_req_o = '{wr: wr, rd: !wr, addr: a, be: 4'hf, wdata: wd};
    @(negedge core_clk_i);
    // released lines show no stale value
    cfg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: 4'h0, wdata: ~wd};
  endtask
endmodule

/* File: testbench/tb_top.sv */
`include "lpdc_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    core_clk_i = 1'b0;
  logic                    rst_i      = 1'b1;
  logic                    shared     = 1'b0;
  logic                    sbr        = 1'b0;
  logic                    idle       = 1'b0;
  lpdc_pkg::lpdc_cfg_req_t req;
  logic [31:0]             rdata;
  logic [2:0]              lat;
  logic [7:0]              fts;
  logic                    sbo;
  logic                    l1r;
  logic                    l0r;
  int                      miscompares = 0;
  int                      checks      = 0;

  always #20 core_clk_i = ~core_clk_i;

  lpdc_cfg_agent peer (.core_clk_i(core_clk_i), .cfg_req_o(req));

  lpdc_top dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cfg_req_i(req), .shared_refclk_config_bit_i(shared),
    .secondary_bus_reset_request_i(sbr), .link_idle_i(idle), .cfg_rdata_o(rdata),
    .reported_l1_exit_latency_o(lat), .fast_train_count_o(fts), .secondary_bus_reset_o(sbo),
    .l1_entry_req_o(l1r), .standby_entry_req_o(l0r)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic do_reset;
    @(negedge core_clk_i);
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    cyc(2);
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [31:0] e);
    peer.access(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask

  task automatic t_defaults;
    read_chk(`LPDC_OFS_ONE, `LPDC_RST_ONE);
    read_chk(`LPDC_OFS_TWO, `LPDC_RST_TWO);
    read_chk(8'hcc, 32'h0);
    chk({29'h0, lat}, 32'h4);
    chk({24'h0, fts}, 32'h32);
    shared = 1'b1;
    cyc(2);
    chk({24'h0, fts}, 32'h14);
  endtask

  task automatic t_write;
    peer.access(1'b1, `LPDC_OFS_ONE, 32'hffea8400);
    peer.access(1'b1, 8'hcc, 32'hffffffff);
    read_chk(`LPDC_OFS_ONE, 32'h000a8400);
    chk({29'h0, lat}, 32'h2);
    peer.access(1'b1, `LPDC_OFS_TWO, 32'h11223344);
    read_chk(`LPDC_OFS_TWO, (`LPDC_RST_TWO & ~`LPDC_WMASK_TWO) | (32'h11223344 & `LPDC_WMASK_TWO));
    chk({24'h0, fts}, 32'h22);
    shared = 1'b0;
    cyc(2);
    chk({29'h0, lat}, 32'h5);
    chk({24'h0, fts}, 32'h11);
    sbr = 1'b1;
    cyc(3);
    chk({31'h0, sbo}, 32'h0);
    do_reset;
    chk({31'h0, sbo}, 32'h1);
    sbr = 1'b0;
    read_chk(`LPDC_OFS_ONE, `LPDC_RST_ONE);
    read_chk(`LPDC_OFS_TWO, `LPDC_RST_TWO);
  endtask

  // both timers run together; hold-off is field times tick length, plus one cycle for the registered request
  task automatic t_timers;
    int n;
    int n0;
    int n1;
    n0 = 0;
    n1 = 0;
    idle = 1'b1;
    for (n = 1; n <= 80 && n1 == 0; n++)
    begin
      cyc(1);
      if (l0r === 1'b1 && n0 == 0)
        n0 = n;
      if (l1r === 1'b1)
        n1 = n;
    end
    chk(n0, 2 * `LPDC_L0S_TICK_CYC + 1);
    chk(n1, 4 * `LPDC_L1_TICK_CYC + 1);
    idle = 1'b0;
    cyc(2);
    chk({30'h0, l1r, l0r}, 32'h0);
    if (n1 == 0)
      finish_test();
  endtask

  initial
  begin
    do_reset;
    t_defaults;
    t_write;
    t_timers;
    finish_test();
  end
endmodule
